/* design/dlm_link_bridge.sv */
// Operation
// - First field is opcode byte, fixed values
// - Response opcode 0x80 success, 0x81 failure
// - Reads, writes, swap, flush, purge of words
// - Forwarded address top byte is module code
// - Response transaction id must match request
// - One load mask applies to every word
// - Padding bits carry any value, ignored
// - Output nibbles: low nibble, then high
// - One outstanding request until response returned
// - Address names first word, linear wrapping order
// - Two words: address bit 3 picks first
// - Four words: bits 4:3 give first word
// - Mask lane offset depends on endian mode
// - Address top byte names target module
// - Two-word load: bit 3 is critical word
// - Four-word load: bits 4:3 critical word
// - Bytes with mask zero are invalid
// - Load response carries opcode, ids, data
// - Store carries one mask per word
`timescale 1ns/1ns
module dlm_link_bridge import dlm_pkg::*; (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         big_endian,
  input  wire logic         req_valid,
  output logic              req_ready,
  input  wire logic [7:0]   req_opcode,
  input  wire logic [31:0]  req_addr,
  input  wire logic [7:0]   req_src,
  input  wire logic [7:0]   req_tid,
  input  wire logic [31:0]  req_mask,
  input  wire logic [255:0] req_data,
  output logic              rsp_valid,
  input  wire logic         rsp_ready,
  output logic              rsp_error,
  output logic [7:0]        rsp_src,
  output logic [7:0]        rsp_tid,
  output logic [255:0]      rsp_data,
  output logic [31:0]       rsp_byte_valid,
  output logic [2:0]        rsp_first_offset,
  output logic              link_out_clk,
  output logic              link_out_sync,
  output logic [3:0]        link_output_nibble,
  input  wire logic         link_in_clk,
  input  wire logic         link_in_sync,
  input  wire logic [3:0]   link_input_nibble
);

  typedef struct packed {
    dlm_state_t   st;
    logic [7:0]   opc;
    logic [31:0]  addr;
    logic [7:0]   src;
    logic [7:0]   tid;
    logic [31:0]  msk;
    logic [255:0] data;
    logic [2:0]   first_off;
    logic [2:0]   tx_hdr;
    logic         tx_body;
    logic [1:0]   tx_slot;
    logic [3:0]   tx_pos;
    logic         clk_s1;
    logic         clk_s2;
    logic         clk_d;
    logic         sync_s1;
    logic         sync_s2;
    logic         sync_d;
    logic [3:0]   nib_s1;
    logic [3:0]   nib_s2;
    logic         rx_half;
    logic [3:0]   rx_low;
    logic [5:0]   rx_cnt;
    logic [7:0]   rx_opc;
    logic [7:0]   rx_src;
    logic [7:0]   rx_tid;
    logic [255:0] rx_data;
    logic         rsp_err;
    logic [7:0]   rsp_src;
    logic [7:0]   rsp_tid;
    logic [255:0] rsp_data;
    logic [31:0]  rsp_bv;
    logic [2:0]   rsp_off;
  } dlm_regs_t;

  dlm_regs_t  q;
  dlm_regs_t  next_q;

  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] tx_byte;
  logic       tx_last;
  logic [1:0] wmask;
  logic [1:0] start_word;
  logic [1:0] tx_word;
  logic [2:0] tx_lane;
  logic [5:0] rsp_len;
  logic [5:0] rx_j;
  logic [1:0] rx_word;
  logic [7:0] rx_byte;
  logic       rx_byte_evt;
  logic       frame_start;
  logic       frame_end;
  logic       rsp_ok;

  always_comb begin
    next_q      = q;
    req_ready   = (q.st == ST_IDLE);
    rsp_valid   = (q.st == ST_DONE);
    tx_valid    = 1'b0;
    wmask       = dlm_word_mask(q.opc);
    start_word  = q.addr[4:3] & wmask;
    tx_word     = (start_word + q.tx_slot) & wmask;
    tx_lane     = 3'(q.tx_pos - 4'h1);
    rsp_len     = RSP_HDR_BYTES;
    if (dlm_has_rdata(q.opc)) begin
      rsp_len = RSP_HDR_BYTES + 6'({1'b0, wmask, 3'b000}) + WORD_BYTES;
    end

    // Outgoing byte picked from the held request
    if (!q.tx_body) begin
      case (q.tx_hdr)
        3'h0:    tx_byte = q.opc;
        3'h1:    tx_byte = q.addr[31:24];
        3'h2:    tx_byte = q.addr[23:16];
        3'h3:    tx_byte = q.addr[15:8];
        3'h4:    tx_byte = q.addr[7:0];
        3'h5:    tx_byte = q.src;
        3'h6:    tx_byte = q.tid;
        default: tx_byte = DUMMY_BYTE;
      endcase
    end else if (dlm_is_load(q.opc)) begin
      tx_byte = q.msk[7:0];
    end else if (q.tx_pos == 4'h0) begin
      tx_byte = dlm_is_cache(q.opc) ? DUMMY_BYTE : q.msk[{tx_word, 3'b000} +: 8];
    end else begin
      tx_byte = q.data[{tx_word, tx_lane, 3'b000} +: 8];
    end
    tx_last = q.tx_body &&
              (dlm_is_load(q.opc) || (q.tx_pos == SLOT_LAST_POS && q.tx_slot == wmask));

    // Link input: two flops per pin before any use
    next_q.clk_s1  = link_in_clk;
    next_q.clk_s2  = q.clk_s1;
    next_q.clk_d   = q.clk_s2;
    next_q.sync_s1 = link_in_sync;
    next_q.sync_s2 = q.sync_s1;
    next_q.sync_d  = q.sync_s2;
    next_q.nib_s1  = link_input_nibble;
    next_q.nib_s2  = q.nib_s1;

    // Sync must lead the first clock edge by a few cycles of clk
    frame_start = q.sync_s2 && !q.sync_d;
    frame_end   = !q.sync_s2 && q.sync_d;
    rx_byte_evt = q.clk_s2 && !q.clk_d && q.sync_s2 && q.rx_half;
    rx_byte     = {q.nib_s2, q.rx_low};
    rx_j        = q.rx_cnt - RSP_HDR_BYTES;
    rx_word     = (start_word + rx_j[4:3]) & wmask;
    rsp_ok      = q.rx_opc == RSP_SUCCESS && q.rx_tid == q.tid &&
                  q.rx_src == q.src && q.rx_cnt == rsp_len;

    if (frame_start) begin
      next_q.rx_half = 1'b0;
      next_q.rx_cnt  = 6'h00;
    end else if (q.clk_s2 && !q.clk_d && q.sync_s2) begin
      next_q.rx_half = !q.rx_half;
      if (!q.rx_half) begin
        next_q.rx_low = q.nib_s2;
      end else begin
        next_q.rx_cnt = q.rx_cnt + 6'h01;
      end
    end

    // Frames outside the wait state are dropped; stray replies cannot land
    if (rx_byte_evt && q.st == ST_WAIT) begin
      if (q.rx_cnt == 6'h00) begin
        next_q.rx_opc = rx_byte;
      end else if (q.rx_cnt == 6'h01) begin
        next_q.rx_src = rx_byte;
      end else if (q.rx_cnt == 6'h02) begin
        next_q.rx_tid = rx_byte;
      end else if (q.rx_cnt < rsp_len) begin
        next_q.rx_data[{rx_word, rx_j[2:0], 3'b000} +: 8] = rx_byte;
      end
    end

    unique case (q.st)
      ST_IDLE: begin
        if (req_valid) begin
          next_q.st        = ST_SEND;
          next_q.opc       = req_opcode;
          next_q.addr      = {DEBUG_MODULE_DEV_CODE, req_addr[23:0]};
          next_q.src       = req_src;
          next_q.tid       = req_tid;
          next_q.msk       = req_mask;
          next_q.data      = req_data;
          next_q.first_off = dlm_first_offset(req_mask[7:0], big_endian);
          next_q.tx_hdr    = 3'h0;
          next_q.tx_body   = 1'b0;
          next_q.tx_slot   = 2'b00;
          next_q.tx_pos    = 4'h0;
          next_q.rx_data   = '0;
        end
      end
      ST_SEND: begin
        tx_valid = 1'b1;
        if (tx_ready) begin
          if (!q.tx_body) begin
            if (q.tx_hdr == HDR_LAST_IDX) begin
              next_q.tx_body = 1'b1;
            end else begin
              next_q.tx_hdr = q.tx_hdr + 3'h1;
            end
          end else if (tx_last) begin
            next_q.st = ST_WAIT;
          end else if (q.tx_pos == SLOT_LAST_POS) begin
            next_q.tx_pos  = 4'h0;
            next_q.tx_slot = q.tx_slot + 2'b01;
          end else begin
            next_q.tx_pos = q.tx_pos + 4'h1;
          end
        end
      end
      ST_WAIT: begin
        if (frame_end) begin
          next_q.st       = ST_DONE;
          next_q.rsp_err  = !rsp_ok;
          next_q.rsp_src  = q.rx_src;
          next_q.rsp_tid  = q.rx_tid;
          next_q.rsp_off  = q.first_off;
          next_q.rsp_data = rsp_ok ? q.rx_data : '0;
          next_q.rsp_bv   = '0;
          for (int w = 0; w < 4; w++) begin
            if (rsp_ok && dlm_has_rdata(q.opc) && 2'(w) <= wmask) begin
              next_q.rsp_bv[w*8 +: 8] = q.msk[7:0];
            end
          end
        end
      end
      ST_DONE: begin
        // Next request waits until this answer leaves the bridge
        if (rsp_ready) next_q.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rsp_error        = q.rsp_err;
  assign rsp_src          = q.rsp_src;
  assign rsp_tid          = q.rsp_tid;
  assign rsp_data         = q.rsp_data;
  assign rsp_byte_valid   = q.rsp_bv;
  assign rsp_first_offset = q.rsp_off;

  dlm_tx_nibble u_tx (
    .clk                (clk),
    .rst_n              (rst_n),
    .byte_valid         (tx_valid),
    .byte_data          (tx_byte),
    .byte_last          (tx_last),
    .byte_ready         (tx_ready),
    .link_out_clk       (link_out_clk),
    .link_out_sync      (link_out_sync),
    .link_output_nibble (link_output_nibble)
  );

  default clocking dlm_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Held request must not be overwritten while one is outstanding
  property p_single_outstanding;
    (q.st != ST_IDLE) |-> (!req_ready ##1 ($stable(q.opc) && $stable(q.tid)));
  endproperty
  a_single_outstanding: assert property (p_single_outstanding)
    else $error("request accepted while one is outstanding");

  property p_ready_after_rsp;
    (rsp_valid && rsp_ready) |=> req_ready;
  endproperty
  a_ready_after_rsp: assert property (p_ready_after_rsp)
    else $error("bridge not ready after response returned");

  property p_opcode_first;
    (tx_valid && tx_ready && !q.tx_body && q.tx_hdr == 3'h0) |-> tx_byte == q.opc;
  endproperty
  a_opcode_first: assert property (p_opcode_first)
    else $error("first message byte is not the opcode");

  property p_module_code;
    (req_valid && req_ready) |=> q.addr[31:24] == DEBUG_MODULE_DEV_CODE;
  endproperty
  a_module_code: assert property (p_module_code)
    else $error("forwarded address lacks module code");

  property p_crit_word;
    (tx_valid && q.tx_body && q.tx_slot == 2'b00 && q.tx_pos == 4'h1 &&
     q.opc == WRITE_FOUR_WORDS_CMD) |-> tx_byte == q.data[{q.addr[4:3], 6'h00} +: 8];
  endproperty
  a_crit_word: assert property (p_crit_word)
    else $error("four-word write does not start at critical word");

  property p_tid_mismatch;
    (q.st == ST_WAIT && frame_end && q.rx_tid != q.tid) |=> (rsp_valid && rsp_error);
  endproperty
  a_tid_mismatch: assert property (p_tid_mismatch)
    else $error("mismatched transaction id not flagged");

  property p_failure_error;
    (q.st == ST_WAIT && frame_end && q.rx_opc == RSP_FAILURE) |=>
      (rsp_error && rsp_data == '0 && rsp_byte_valid == '0);
  endproperty
  a_failure_error: assert property (p_failure_error)
    else $error("failure response not turned into error");

  property p_load_mask_reuse;
    (rsp_valid && !rsp_error && q.opc == READ_FOUR_WORDS_CMD) |->
      rsp_byte_valid == {4{q.msk[7:0]}};
  endproperty
  a_load_mask_reuse: assert property (p_load_mask_reuse)
    else $error("load mask not applied to every word");

  property p_rsp_holds;
    (rsp_valid && !rsp_ready) |=> (rsp_valid && $stable(rsp_data) && $stable(rsp_error));
  endproperty
  a_rsp_holds: assert property (p_rsp_holds)
    else $error("response changed before it was taken");

  c_read_four_words_cmd_ok:   cover property (rsp_valid && !rsp_error && q.opc == READ_FOUR_WORDS_CMD);
  c_write_two_words_cmd_ok:  cover property (rsp_valid && !rsp_error && q.opc == WRITE_TWO_WORDS_CMD);
  c_fail_rsp:    cover property (rsp_valid && rsp_error);
  c_swap_ok:     cover property (rsp_valid && !rsp_error && q.opc == ATOMIC_EXCHANGE_CMD);

endmodule

/* design/dlm_pkg.sv */
package dlm_pkg;

  localparam logic [7:0] READ_ONE_WORD_CMD     = 8'h31;
  localparam logic [7:0] READ_TWO_WORDS_CMD    = 8'h41;
  localparam logic [7:0] READ_FOUR_WORDS_CMD   = 8'h51;
  localparam logic [7:0] WRITE_ONE_WORD_CMD    = 8'h32;
  localparam logic [7:0] WRITE_TWO_WORDS_CMD   = 8'h42;
  localparam logic [7:0] WRITE_FOUR_WORDS_CMD  = 8'h52;
  localparam logic [7:0] ATOMIC_EXCHANGE_CMD   = 8'h35;
  localparam logic [7:0] FLUSH_CMD             = 8'h18;
  localparam logic [7:0] PURGE_CMD             = 8'h08;
  localparam logic [7:0] RSP_SUCCESS           = 8'h80;
  localparam logic [7:0] RSP_FAILURE           = 8'h81;

  // Bus device code of the debug module; value is arbitrary
  localparam logic [7:0] DEBUG_MODULE_DEV_CODE = 8'hD0;
  localparam logic [7:0] DUMMY_BYTE            = 8'h00;

  localparam logic [2:0] HDR_LAST_IDX          = 3'h6;
  localparam logic [3:0] SLOT_LAST_POS         = 4'h8;
  localparam logic [5:0] RSP_HDR_BYTES         = 6'h03;
  localparam logic [5:0] WORD_BYTES            = 6'h08;

  localparam int         CLK_NS                = 40;
  localparam int         LINK_HALF_NS          = 80;
  localparam int         LINK_HALF_CYC         = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] LINK_HALF_LAST        = 4'(LINK_HALF_CYC - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b11,
    ST_DONE = 2'b10
  } dlm_state_t;

  function automatic logic [1:0] dlm_word_mask(input logic [7:0] opc);
    logic [1:0] m;
    m = 2'b00;
    if (opc == READ_TWO_WORDS_CMD || opc == WRITE_TWO_WORDS_CMD) begin
      m = 2'b01;
    end else if (opc == READ_FOUR_WORDS_CMD || opc == WRITE_FOUR_WORDS_CMD) begin
      m = 2'b11;
    end
    return m;
  endfunction

  function automatic logic dlm_is_load(input logic [7:0] opc);
    return opc == READ_ONE_WORD_CMD || opc == READ_TWO_WORDS_CMD ||
           opc == READ_FOUR_WORDS_CMD;
  endfunction

  function automatic logic dlm_has_rdata(input logic [7:0] opc);
    return dlm_is_load(opc) || opc == ATOMIC_EXCHANGE_CMD;
  endfunction

  function automatic logic dlm_is_cache(input logic [7:0] opc);
    return opc == FLUSH_CMD || opc == PURGE_CMD;
  endfunction

  function automatic logic [2:0] dlm_first_offset(input logic [7:0] m, input logic be);
    logic [2:0] lo;
    logic [2:0] hi;
    lo = 3'h0;
    hi = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) lo = 3'(i);
    end
    for (int i = 0; i < 8; i++) begin
      if (m[i]) hi = 3'(i);
    end
    return be ? 3'h7 - hi : lo;
  endfunction

endpackage

/* design/dlm_tx_nibble.sv */
`timescale 1ns/1ns
module dlm_tx_nibble import dlm_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic       byte_last,
  output logic            byte_ready,
  output logic            link_out_clk,
  output logic            link_out_sync,
  output logic [3:0]      link_output_nibble
);

  typedef struct packed {
    logic       busy;
    logic       half;
    logic [3:0] cnt;
    logic       clko;
    logic       sync;
    logic [7:0] byte_q;
    logic       last;
    logic [3:0] nib;
  } dlm_tx_regs_t;

  dlm_tx_regs_t q;
  dlm_tx_regs_t next_q;

  always_comb begin
    next_q     = q;
    byte_ready = !q.busy;
    if (!q.busy) begin
      if (byte_valid) begin
        next_q.busy   = 1'b1;
        next_q.half   = 1'b0;
        next_q.cnt    = 4'h0;
        next_q.clko   = 1'b0;
        next_q.sync   = 1'b1;
        next_q.byte_q = byte_data;
        next_q.last   = byte_last;
        next_q.nib    = byte_data[3:0];
      end
    end else if (q.cnt == LINK_HALF_LAST) begin
      next_q.cnt  = 4'h0;
      next_q.clko = !q.clko;
      // Data moves on the falling edge so the tool samples it mid-period
      if (q.clko) begin
        if (!q.half) begin
          next_q.half = 1'b1;
          next_q.nib  = q.byte_q[7:4];
        end else begin
          next_q.busy = 1'b0;
          next_q.half = 1'b0;
          if (q.last) next_q.sync = 1'b0;
        end
      end
    end else begin
      next_q.cnt = q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign link_out_clk       = q.clko;
  assign link_out_sync      = q.sync;
  assign link_output_nibble = q.nib;

  property p_low_nibble_first;
    @(posedge clk) disable iff (!rst_n)
      (q.busy && !q.half && $rose(q.clko)) |-> link_output_nibble == q.byte_q[3:0];
  endproperty
  a_low_nibble_first: assert property (p_low_nibble_first)
    else $error("low nibble not on link at first rising edge");

  property p_high_nibble_second;
    @(posedge clk) disable iff (!rst_n)
      $rose(q.half) |-> (link_output_nibble == q.byte_q[7:4] && !link_out_clk);
  endproperty
  a_high_nibble_second: assert property (p_high_nibble_second)
    else $error("high nibble not following low nibble");

endmodule

/* sim/dlm_link_bridge_tb.sv */
`timescale 1ns/1ns
module dlm_link_bridge_tb import dlm_pkg::*;;
  logic clk = 1'b0, rst_n, big_endian, req_valid, req_ready, rsp_valid, rsp_ready, rsp_error;
  logic [7:0] req_opcode, req_src, req_tid, rsp_src, rsp_tid;
  logic [31:0] req_addr, req_mask, rsp_byte_valid;
  logic [255:0] req_data, rsp_data, words;
  logic [2:0] rsp_first_offset;
  logic [3:0] out_nib, in_nib;
  logic out_clk, out_sync, in_clk, in_sync, fail, bad_tid;
  logic [7:0] exp[$];
  int err_total = 0, num_checks = 0;

  always #20 clk = ~clk;

  dlm_link_bridge dlm_link_bridge_i (.clk(clk), .rst_n(rst_n), .big_endian(big_endian),
    .req_valid(req_valid), .req_ready(req_ready), .req_opcode(req_opcode),
    .req_addr(req_addr), .req_src(req_src), .req_tid(req_tid), .req_mask(req_mask),
    .req_data(req_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_error(rsp_error), .rsp_src(rsp_src), .rsp_tid(rsp_tid), .rsp_data(rsp_data),
    .rsp_byte_valid(rsp_byte_valid), .rsp_first_offset(rsp_first_offset),
    .link_out_clk(out_clk), .link_out_sync(out_sync), .link_output_nibble(out_nib),
    .link_in_clk(in_clk), .link_in_sync(in_sync), .link_input_nibble(in_nib));

  dlm_tool_model dlm_tool_model_i (.link_out_clk(out_clk), .link_out_sync(out_sync),
    .link_output_nibble(out_nib), .link_in_clk(in_clk), .link_in_sync(in_sync),
    .link_input_nibble(in_nib), .fail(fail), .bad_tid(bad_tid), .words(words));

  task automatic check(string what, logic [255:0] e, logic [255:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask

  function automatic logic [2:0] exp_off(logic [7:0] m, logic be);
    int lo;
    int hi;
    lo = 8;
    hi = 0;
    for (int i = 0; i < 8; i++) if (m[i]) begin
      if (lo == 8) lo = i;
      hi = i;
    end
    return be ? 3'(7 - hi) : 3'(lo);
  endfunction

  task automatic run_op(logic [7:0] opc, logic [31:0] a, logic [7:0] m, logic be, fl, bt);
    int n;
    int w;
    int i;
    logic rd;
    logic [31:0] bv;
    logic [255:0] dm;
    n = (opc inside {READ_TWO_WORDS_CMD, WRITE_TWO_WORDS_CMD}) ? 2 :
        (opc inside {READ_FOUR_WORDS_CMD, WRITE_FOUR_WORDS_CMD}) ? 4 : 1;
    rd = opc inside {READ_ONE_WORD_CMD, READ_TWO_WORDS_CMD, READ_FOUR_WORDS_CMD};
    exp = {opc, DEBUG_MODULE_DEV_CODE, a[23:16], a[15:8], a[7:0], 8'hA5, opc};
    if (rd) exp.push_back(m);
    else if (opc inside {FLUSH_CMD, PURGE_CMD}) begin
      exp.push_back(8'h00);
      for (int b = 0; b < 8; b++) exp.push_back(req_data[8*b +: 8]);
    end else for (int k = 0; k < n; k++) begin
      w = (int'(a[4:3]) + k) % n;
      exp.push_back(m ^ 8'(w));
      for (int b = 0; b < 8; b++) exp.push_back(req_data[64*w+8*b +: 8]);
    end
    rd = rd || opc == ATOMIC_EXCHANGE_CMD;
    @(posedge clk);
    {req_valid, req_opcode, req_addr, req_src, req_tid} <= {1'b1, opc, a, 8'hA5, opc};
    {req_mask, big_endian, fail, bad_tid} <= {m ^ 8'h03, m ^ 8'h02, m ^ 8'h01, m, be, fl, bt};
    @(posedge clk);
    req_valid <= 1'b0;
    for (i = 0; i < 3000 && rsp_valid !== 1'b1; i++) begin
      @(negedge clk);
      if (rsp_valid !== 1'b1) check("req_ready while busy", 0, req_ready);
    end
    if (i >= 3000) check("response arrival", 1, 0);
    check("frame length", exp.size(), dlm_tool_model_i.rx_n);
    foreach (exp[k]) if (!(k == 7 && opc inside {FLUSH_CMD, PURGE_CMD}))
      check("frame byte", exp[k], dlm_tool_model_i.rx[k]);
    check("rsp_error", fl | bt, rsp_error);
    check("rsp_src", 8'hA5, rsp_src);
    check("rsp_tid", opc ^ {7'h00, bt}, rsp_tid);
    bv = '0;
    dm = '1 >> (256 - 64 * n);
    if (rd && !fl && !bt) begin
      for (w = 0; w < n; w++) bv[8*w +: 8] = m;
      check("rsp_data", words & dm, rsp_data & dm);
      check("rsp_first_offset", exp_off(m, be), rsp_first_offset);
    end else if (fl | bt) check("rsp_data", 0, rsp_data);
    check("rsp_byte_valid", bv, rsp_byte_valid);
    @(posedge clk);
    rsp_ready <= 1'b1;
    @(posedge clk);
    rsp_ready <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("req_ready after reply", 1, req_ready);
  endtask

  task automatic t_reads();
    run_op(READ_FOUR_WORDS_CMD, 32'h1200_0000, 8'h0F, 0, 0, 0);
    for (int s = 1; s < 4; s++)
      run_op(READ_FOUR_WORDS_CMD, 32'h1234_5607 | 32'(s << 3), 8'hF0, 1, 0, 0);
    run_op(READ_TWO_WORDS_CMD, 32'h3400_0008, 8'h0C, 1, 0, 0);
    run_op(READ_TWO_WORDS_CMD, 32'h3400_0010, 8'h80, 0, 0, 0);
    run_op(READ_ONE_WORD_CMD, 32'hFF00_0005, 8'h01, 1, 0, 0);
    $display("reads test finished, mismatches %0d", err_total);
  endtask

  task automatic t_writes();
    run_op(WRITE_ONE_WORD_CMD, 32'h5600_0040, 8'hFF, 0, 0, 0);
    run_op(WRITE_TWO_WORDS_CMD, 32'h5600_0048, 8'h30, 0, 0, 0);
    run_op(WRITE_FOUR_WORDS_CMD, 32'h5600_0018, 8'h3C, 0, 0, 0);
    run_op(ATOMIC_EXCHANGE_CMD, 32'h7800_0100, 8'h0C, 1, 0, 0);
    run_op(FLUSH_CMD, 32'h9A00_0200, 8'h00, 0, 0, 0);
    run_op(PURGE_CMD, 32'h9A00_0208, 8'h00, 0, 0, 0);
    $display("writes test finished, mismatches %0d", err_total);
  endtask

  task automatic t_faults();
    run_op(READ_FOUR_WORDS_CMD, 32'h1200_0010, 8'hFF, 0, 1, 0);
    run_op(WRITE_TWO_WORDS_CMD, 32'h5600_0008, 8'h0F, 0, 0, 1);
    run_op(READ_ONE_WORD_CMD, 32'h1200_0020, 8'h02, 0, 0, 0);
    $display("faults test finished, mismatches %0d", err_total);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {rst_n, big_endian, req_valid, rsp_ready, fail, bad_tid} = '0;
    {req_opcode, req_addr, req_src, req_tid, req_mask} = '0;
    req_data = 256'h0F1E2D3C4B5A6978_8796A5B4C3D2E1F0_1122334455667788_99AABBCCDDEEFF01;
    words = 256'hCAFE0004BEEF0003_DEAD0002FACE0001_0123456789ABCDEF_FEDCBA9876543210;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reads();
    t_writes();
    t_faults();
    report_and_stop();
  end

  // Roughly six times the expected run length
  initial begin
    #(40 * 40000);
    err_total++;
    $display("unexpected watchdog expiry: expected 0 seen 1");
    report_and_stop();
  end
endmodule

/* sim/dlm_tool_model.sv */
`timescale 1ns/1ns
module dlm_tool_model import dlm_pkg::*; (
  input  wire logic         link_out_clk,
  input  wire logic         link_out_sync,
  input  wire logic [3:0]   link_output_nibble,
  output logic              link_in_clk,
  output logic              link_in_sync,
  output logic [3:0]        link_input_nibble,
  input  wire logic         fail,
  input  wire logic         bad_tid,
  input  wire logic [255:0] words
);
  logic [7:0] rx [0:63];
  int         rx_n;
  logic       hi;
  logic [3:0] lo;

  initial begin
    link_in_clk = 1'b0;
    link_in_sync = 1'b0;
    link_input_nibble = 4'h0;
  end

  always @(posedge link_out_sync) begin
    rx_n = 0;
    hi = 1'b0;
  end

  always @(posedge link_out_clk) begin
    if (link_out_sync && rx_n < 64) begin
      if (hi) begin
        rx[rx_n] = {link_output_nibble, lo};
        rx_n++;
      end else begin
        lo = link_output_nibble;
      end
      hi = !hi;
    end
  end

  // Answers only a finished device frame, never on its own
  // Reset drives sync from unknown to low; no frame seen yet, so no reply
  always @(negedge link_out_sync) begin
    if (rx_n > 0) send_reply();
  end

  task automatic send_reply();
    logic [7:0] q[$];
    int         n;
    int         w;
    n = (rx[0] == READ_TWO_WORDS_CMD) ? 2 : (rx[0] == READ_FOUR_WORDS_CMD) ? 4 : 1;
    // Reply carries no address field, so never the remote memory code
    q = {fail ? RSP_FAILURE : RSP_SUCCESS, rx[5], rx[6] ^ {7'h00, bad_tid}};
    // All bytes returned valid, mask ignored
    if (!fail && rx[0] inside {READ_ONE_WORD_CMD, READ_TWO_WORDS_CMD,
                               READ_FOUR_WORDS_CMD, ATOMIC_EXCHANGE_CMD}) begin
      for (int k = 0; k < n; k++) begin
        w = (int'(rx[4][4:3]) + k) % n;
        for (int b = 0; b < 8; b++) q.push_back(words[64*w+8*b +: 8]);
      end
    end
    // Odd delay keeps the reply out of phase with the device clock
    #1013;
    link_in_sync = 1'b1;
    foreach (q[i]) begin
      for (int h = 0; h < 2; h++) begin
        link_input_nibble = h ? q[i][7:4] : q[i][3:0];
        #160 link_in_clk = 1'b1;
        #160 link_in_clk = 1'b0;
      end
    end
    #160 link_in_sync = 1'b0;
    link_input_nibble = ~link_input_nibble;
  endtask
endmodule
